// ==== test/rbc_backplane_monitor.sv ====
// Checker of backplane wire levels between the two ends
`timescale 1ns/100ps
module rbc_backplane_monitor (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic isolate_out_10m,
	input wire logic isolate_out_100m,
	input wire logic coll_sense_local_10m_n,
	input wire logic coll_sense_stack_10m_n,
	input wire logic data_valid_100m_n,
	input wire logic driver_enable_10m_n,
	input wire logic driver_enable_100m_n,
	input wire logic mgmt_master_chain
);
	// =========================================
	// Wire relations, one clock domain
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	a_coll_pair_match:
	assert property (coll_sense_local_10m_n == coll_sense_stack_10m_n) else $error("coll pair");
	a_iso10_reset_low:
	assert property ($past(reset_in) |-> !isolate_out_10m) else $error("iso10 reset");
	a_iso100_reset_low:
	assert property ($past(reset_in) |-> !isolate_out_100m) else $error("iso100 reset");
	a_coll_reset_idle:
	assert property ($past(reset_in) |-> coll_sense_local_10m_n) else $error("coll reset");
	a_valid_reset_idle:
	assert property ($past(reset_in) |-> data_valid_100m_n) else $error("valid reset");
	a_den10_reset_idle:
	assert property ($past(reset_in) |-> driver_enable_10m_n) else $error("den10 reset");
	a_den100_reset_idle:
	assert property ($past(reset_in) |-> driver_enable_100m_n) else $error("den100 reset");
	a_chain_reset_low:
	assert property ($past(reset_in) |-> !mgmt_master_chain) else $error("chain reset");
	// Main traffic seen at least once
	cover property (!coll_sense_local_10m_n);
	cover property (isolate_out_10m && isolate_out_100m);
	cover property (!data_valid_100m_n);
endmodule : rbc_backplane_monitor

// ==== test/tb.sv ====
// Testbench joining both backplane ends under random stimulus
`timescale 1ns/100ps
module tb;
	import rbc_pkg::*;
	logic mclk_in = 0, reset_in = 1, i10 = 0, i100 = 0, mac = 0;
	logic t100 = 0, t10 = 0, d10 = 0, fst = 0, up = 0;
	logic [1:0] st = 0;
	logic [4:0] dt = 0, rxd;
	logic [2:0] cid;
	logic ism, mmo, be10, be100, col, rxv;
	logic [31:0] r = 32'h626ed258;
	int errors = 0, checks = 0;
	rbc_backplane_if bp();
	rbc_device_end i_rbc_device_end (.mclk_in(mclk_in), .reset_in(reset_in), .bp(bp),
		.chip_strap_in(st), .iso_10m_cfg_in(i10), .iso_100m_cfg_in(i100),
		.ext_mac_active_in(mac), .tx_100m_in(t100), .tx_data_100m_in(dt), .tx_10m_in(t10),
		.tx_data_10m_in(d10), .chip_identifier_out(cid), .is_master_chip_out(ism),
		.mgmt_master_out(mmo));
	rbc_partner_end i_rbc_partner_end (.mclk_in(mclk_in), .reset_in(reset_in), .bp(bp),
		.first_in_chain_in(fst), .upstream_master_in(up), .buffer_enable_10m_out(be10),
		.buffer_enable_100m_out(be100), .collision_10m_out(col), .rx_data_100m_out(rxd),
		.rx_valid_100m_out(rxv));
	rbc_backplane_monitor i_mon (.mclk_in(mclk_in), .reset_in(reset_in),
		.isolate_out_10m(bp.isolate_out_10m), .isolate_out_100m(bp.isolate_out_100m),
		.coll_sense_local_10m_n(bp.coll_sense_local_10m_n),
		.coll_sense_stack_10m_n(bp.coll_sense_stack_10m_n),
		.data_valid_100m_n(bp.data_valid_100m_n), .driver_enable_10m_n(bp.driver_enable_10m_n),
		.driver_enable_100m_n(bp.driver_enable_100m_n),
		.mgmt_master_chain(bp.mgmt_master_chain));
	// Free-running 25 MHz clock
	always #20 mclk_in = ~mclk_in;
	// =========================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	// One input set, then two edges of pipeline before outputs settle
	task step(input logic [31:0] v);
		@(posedge mclk_in);
		#1;
		{st, i10, i100, mac, t100, dt, t10, d10, fst, up} = v[14:0];
		@(posedge mclk_in);
		#1;
		chk(bp.coll_sense_local_10m_n === ~mac, "coll latency");
		@(posedge mclk_in);
		#1;
		chk(bp.isolate_out_10m === i10 && be10 === ~i10, "iso10");
		chk(bp.isolate_out_100m === i100 && be100 === ~i100, "iso100");
		chk(bp.coll_sense_stack_10m_n === ~mac && col === mac, "coll");
		chk(cid === {1'b0, st}, "chip id");
		chk(ism === (st == 2'h0), "owner");
		chk(rxv === t100 && (!t100 || rxd === dt), "data100");
		chk(bp.backplane_data_10m === d10, "data10");
		chk(bp.activity_enable_10m_n === ~t10, "enable10");
		chk(bp.driver_enable_10m_n === ~t10, "den10");
		chk(bp.driver_enable_100m_n === ~t100, "den100");
		if (fst) chk(bp.mgmt_master_chain === 1'b0 && mmo === 1'b1, "chain");
		else chk(bp.mgmt_master_chain === up && mmo === ~up, "chain");
	endtask : step
	// =========================================
	// Main sequence
	initial begin
		repeat (5) @(posedge mclk_in);
		#1;
		chk(cid === 3'h0 && bp.isolate_out_10m === RBC_ISO_RST && mmo === 1'b0, "reset");
		reset_in = 0;
		$display("reset test done");
		// All-zero and all-one corners first, then random sets
		for (int i = 0; i < 80; i++) begin
			r = lfsr(r);
			step(i == 0 ? 32'h0 : (i == 1 ? 32'hffffffff : r));
		end
		$display("random test done");
		complete_run();
	end
endmodule : tb

// ==== verilog/rbc_backplane_if.sv ====
// Interface joining a repeater chip to the rest of its backplane
`timescale 1ns/100ps
interface rbc_backplane_if;
	import rbc_pkg::*;
	// =========================================
	// 100 Mbps segment
	logic [RBC_DAT100_W-1:0] backplane_data_100m;
	logic data_valid_100m_n;
	logic driver_enable_100m_n;
	logic isolate_out_100m;
	// =========================================
	// 10 Mbps segment
	logic backplane_data_10m;
	logic activity_enable_10m_n;
	logic coll_sense_local_10m_n;
	logic coll_sense_stack_10m_n;
	logic driver_enable_10m_n;
	logic isolate_out_10m;
	// Management master chain
	logic mgmt_master_chain;
	modport device (
		output backplane_data_100m, data_valid_100m_n, driver_enable_100m_n,
		output isolate_out_100m, backplane_data_10m, activity_enable_10m_n,
		output coll_sense_local_10m_n, coll_sense_stack_10m_n, driver_enable_10m_n,
		output isolate_out_10m,
		input mgmt_master_chain
	);
	modport partner (
		input backplane_data_100m, data_valid_100m_n, driver_enable_100m_n,
		input isolate_out_100m, backplane_data_10m, activity_enable_10m_n,
		input coll_sense_local_10m_n, coll_sense_stack_10m_n, driver_enable_10m_n,
		input isolate_out_10m,
		output mgmt_master_chain
	);
endinterface : rbc_backplane_if

// ==== verilog/rbc_device_end.sv ====
// Repeater chip end of the inter-repeater backplane
`timescale 1ns/100ps
module rbc_device_end
	import rbc_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	rbc_backplane_if.device bp,
	input wire logic [RBC_STRAP_W-1:0] chip_strap_in,
	input wire logic iso_10m_cfg_in,
	input wire logic iso_100m_cfg_in,
	input wire logic ext_mac_active_in,
	input wire logic tx_100m_in,
	input wire logic [RBC_DAT100_W-1:0] tx_data_100m_in,
	input wire logic tx_10m_in,
	input wire logic tx_data_10m_in,
	output logic [RBC_CHIP_IDENTIFIER_W-1:0] chip_identifier_out,
	output logic is_master_chip_out,
	output logic mgmt_master_out
);
	// =========================================
	// Identity state
	logic [RBC_CHIP_IDENTIFIER_W-1:0] id_q;
	logic [RBC_CHIP_IDENTIFIER_W-1:0] id_d;
	logic owner_q;
	logic owner_d;
	// =========================================
	// Collision-sense state
	logic coll_local_n_q;
	logic coll_local_n_d;
	logic coll_stack_n_q;
	logic coll_stack_n_d;
	// =========================================
	// Isolate state
	logic iso10_q;
	logic iso10_d;
	logic iso100_q;
	logic iso100_d;
	// =========================================
	// 100 Mbps segment state
	logic den100_n_q;
	logic den100_n_d;
	logic dv100_n_q;
	logic dv100_n_d;
	logic [RBC_DAT100_W-1:0] dat100_q;
	logic [RBC_DAT100_W-1:0] dat100_d;
	// =========================================
	// 10 Mbps segment state
	logic den10_n_q;
	logic den10_n_d;
	logic ena10_n_q;
	logic ena10_n_d;
	logic dat10_q;
	logic dat10_d;
	// =========================================
	// Management chain state
	logic mm_q;
	logic mm_d;

	// =========================================
	// Identity
	// Identifier from straps
	// Straps assumed static, captured every clock anyway
	always_comb begin
		id_d = {RBC_ID_TOP_BIT, chip_strap_in};
		owner_d = (id_d == RBC_MASTER_ID);
	end

	// Identity registers, no owner claimed in reset
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			id_q <= RBC_MASTER_ID;
			owner_q <= 1'b0;
		end else begin
			id_q <= id_d;
			owner_q <= owner_d;
		end
	end

	// =========================================
	// Collision sense on behalf of the MAC
	// Registered MAC activity
	// One flop of lag keeps pin glitches off the backplane
	always_comb begin
		coll_local_n_d = ~ext_mac_active_in;
		coll_stack_n_d = ~ext_mac_active_in;
	end

	// Collision-sense registers, lines released in reset
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			coll_local_n_q <= ~RBC_ACT_RST;
			coll_stack_n_q <= ~RBC_ACT_RST;
		end else begin
			coll_local_n_q <= coll_local_n_d;
			coll_stack_n_q <= coll_stack_n_d;
		end
	end

	// =========================================
	// Isolation
	// Isolate follows config bits
	always_comb begin
		iso10_d = iso_10m_cfg_in;
		iso100_d = iso_100m_cfg_in;
	end

	// Isolate registers, board joined during reset
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			iso10_q <= RBC_ISO_RST;
			iso100_q <= RBC_ISO_RST;
		end else begin
			iso10_q <= iso10_d;
			iso100_q <= iso100_d;
		end
	end

	// =========================================
	// 100 Mbps segment
	// Own enable, valid, data
	// Driver enable follows transmit
	// Data lines follow input when idle; valid qualifies them
	always_comb begin
		den100_n_d = ~tx_100m_in;
		dv100_n_d = ~tx_100m_in;
		dat100_d = tx_data_100m_in;
	end

	// 100 Mbps registers, segment quiet in reset
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			den100_n_q <= ~RBC_ACT_RST;
			dv100_n_q <= ~RBC_ACT_RST;
			dat100_q <= '0;
		end else begin
			den100_n_q <= den100_n_d;
			dv100_n_q <= dv100_n_d;
			dat100_q <= dat100_d;
		end
	end

	// =========================================
	// 10 Mbps segment
	// Own enable, activity, data
	always_comb begin
		den10_n_d = ~tx_10m_in;
		ena10_n_d = ~tx_10m_in;
		dat10_d = tx_data_10m_in;
	end

	// 10 Mbps registers, segment quiet in reset
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			den10_n_q <= ~RBC_ACT_RST;
			ena10_n_q <= ~RBC_ACT_RST;
			dat10_q <= 1'b0;
		end else begin
			den10_n_q <= den10_n_d;
			ena10_n_q <= ena10_n_d;
			dat10_q <= dat10_d;
		end
	end

	// =========================================
	// Management master chain
	// Low chain means master
	always_comb begin
		mm_d = ~bp.mgmt_master_chain;
	end

	// Chain register, nobody is master during reset
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			mm_q <= 1'b0;
		end else begin
			mm_q <= mm_d;
		end
	end

	// =========================================
	// Backplane drive, every line straight from a flop
	// Transceiver enable, valid, data and collision-sense outputs
	assign bp.isolate_out_10m = iso10_q;
	assign bp.isolate_out_100m = iso100_q;
	assign bp.driver_enable_100m_n = den100_n_q;
	assign bp.driver_enable_10m_n = den10_n_q;
	assign bp.data_valid_100m_n = dv100_n_q;
	assign bp.backplane_data_100m = dat100_q;
	assign bp.activity_enable_10m_n = ena10_n_q;
	assign bp.backplane_data_10m = dat10_q;
	assign bp.coll_sense_local_10m_n = coll_local_n_q;
	assign bp.coll_sense_stack_10m_n = coll_stack_n_q;

	// Local status outputs
	assign chip_identifier_out = id_q;
	assign is_master_chip_out = owner_q;
	assign mgmt_master_out = mm_q;
endmodule : rbc_device_end

// ==== verilog/rbc_partner_end.sv ====
// Far-side end: other chips and boards seen through buffers
`timescale 1ns/100ps
module rbc_partner_end
	import rbc_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	rbc_backplane_if.partner bp,
	input wire logic first_in_chain_in,
	input wire logic upstream_master_in,
	output logic buffer_enable_10m_out,
	output logic buffer_enable_100m_out,
	output logic collision_10m_out,
	output logic [RBC_DAT100_W-1:0] rx_data_100m_out,
	output logic rx_valid_100m_out
);
	logic chain_q, chain_d;
	logic be10_q, be10_d, be100_q, be100_d;
	logic col_q, col_d;
	logic [RBC_DAT100_W-1:0] rx_q, rx_d;
	logic rxv_q, rxv_d;

	// =========================================
	// Next-state logic
	always_comb begin
		// First chip held low, else chained
		chain_d = first_in_chain_in ? 1'b0 : upstream_master_in;
		// Buffer enables from chip 00 isolate
		be10_d = ~bp.isolate_out_10m;
		be100_d = ~bp.isolate_out_100m;
		// Local or stack collision sense seen on board
		col_d = ~bp.coll_sense_local_10m_n | ~bp.coll_sense_stack_10m_n;
		rx_d = bp.backplane_data_100m;
		rxv_d = ~bp.data_valid_100m_n;
	end

	// Registers
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			chain_q <= 1'b0;
			be10_q <= 1'b0;
			be100_q <= 1'b0;
			col_q <= 1'b0;
			rx_q <= '0;
			rxv_q <= 1'b0;
		end else begin
			chain_q <= chain_d;
			be10_q <= be10_d;
			be100_q <= be100_d;
			col_q <= col_d;
			rx_q <= rx_d;
			rxv_q <= rxv_d;
		end
	end

	// Single chain source drives this line
	assign bp.mgmt_master_chain = chain_q;
	assign buffer_enable_10m_out = be10_q;
	assign buffer_enable_100m_out = be100_q;
	assign collision_10m_out = col_q;
	assign rx_data_100m_out = rx_q;
	assign rx_valid_100m_out = rxv_q;
endmodule : rbc_partner_end

// ==== verilog/rbc_pkg.sv ====
// Package of constants and types shared by both backplane ends
package rbc_pkg;
	// =========================================
	// Widths
	localparam int RBC_DAT100_W = 5;
	localparam int RBC_CHIP_IDENTIFIER_W = 3;
	localparam int RBC_STRAP_W = 2;
	// =========================================
	// Reset values
	localparam logic RBC_ISO_RST = 1'b0;
	localparam logic RBC_ACT_RST = 1'b0;
	localparam logic [RBC_CHIP_IDENTIFIER_W-1:0] RBC_MASTER_ID = 3'h0;
	// Fixed top bit of the chip identifier, placed above the strap bits
	localparam logic RBC_ID_TOP_BIT = 1'b0;
	// Segment driver-enable states
	typedef enum logic [1:0] {
		RBC_SEG_IDLE,
		RBC_SEG_TX,
		RBC_SEG_RX
	} rbc_seg_t;
endpackage : rbc_pkg
